/* asc_map.svh */
// Purpose: Timing figures and pin constants of the SRAM cycle controller
// Assumes: Times in ns, system clock period given below
// Notes:   Counts are derived from the figures by ASC_NS2CYC
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ********************************************************************
// Clock and synchroniser
// ********************************************************************
`define ASC_CLK_PERIOD_NS        10.0
`define ASC_SYNC_STAGES          2

// ********************************************************************
// Read timing, fast and slow grade
// ********************************************************************
`define ASC_T_ACCESS_FAST_NS     45.0
`define ASC_T_ACCESS_SLOW_NS     55.0
`define ASC_T_OE_ACCESS_FAST_NS  22.0
`define ASC_T_OE_ACCESS_SLOW_NS  25.0
`define ASC_T_ADDR_HOLD_NS       10.0
`define ASC_T_TURN_ON_NS         5.0
`define ASC_T_TURN_OFF_NS        18.0

// ********************************************************************
// Write timing, fast and slow grade
// ********************************************************************
`define ASC_T_WEND_FAST_NS       35.0
`define ASC_T_WEND_SLOW_NS       40.0
`define ASC_T_WDATA_SETUP_NS     25.0
`define ASC_T_WDATA_HOLD_NS      0.0
`define ASC_T_ADDR_START_NS      0.0
`define ASC_T_WOFF_FAST_NS       18.0
`define ASC_T_WOFF_SLOW_NS       20.0

// ********************************************************************
// Cycle time and retention
// ********************************************************************
`define ASC_T_CYCLE_FAST_NS      45.0
`define ASC_T_CYCLE_SLOW_NS      55.0
`define ASC_T_DESEL_RET_NS       0.0

// ********************************************************************
// Conversion and pin levels
// ********************************************************************
`define ASC_NS2CYC(t) ((int'($ceil((t) / `ASC_CLK_PERIOD_NS)) < 1) ? 1 : \
	int'($ceil((t) / `ASC_CLK_PERIOD_NS)))
`define ASC_LANES_OFF            2'h3

`endif

/* asc_pkg.sv */
// Purpose: Types of the SRAM cycle controller
// Assumes: Nothing
// Notes:   Constants live in asc_map.svh
package asc_pkg;

	typedef enum logic [2:0] {
		ASC_IDLE,
		ASC_RD_ACCESS,
		ASC_RD_TURN,
		ASC_WR_SETUP,
		ASC_WR_PULSE,
		ASC_WR_HOLD,
		ASC_RETAIN,
		ASC_RECOVER
	} asc_state_t;

	typedef logic [1:0] asc_lane_t;

endpackage

/* asc_timer.sv */
// Purpose: Down counter that times the multi-cycle phases of a memory cycle
// Assumes: Load and count run on the controller clock enable
// Notes:   done is high while the count is zero
module asc_timer #(
	parameter int TW = 4
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          ce,
	input  wire logic          load,
	input  wire logic [TW-1:0] value,
	output logic               done
);

	if (TW < 1) begin : g_bad_tw
		$error("Timer width must be at least 1");
	end

	logic [TW-1:0] cnt_reg;

	// ****************************************************************
	// Counter
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_reg <= '0;
		end else if (ce) begin
			if (load) begin
				cnt_reg <= value;
			end else if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - TW'(1);
			end
		end
	end

	assign done = (cnt_reg == '0);

endmodule

/* asc_sram_ctrl.sv */
// Purpose: Host controller driving an asynchronous ECC SRAM by its pins
// Assumes: 100 MHz clock, 16-bit two-lane memory, data and error pins
//          arrive unsynchronised
// Notes:   One access at a time; write is ended by write enable
// Behaviour
// - Write happens only while strobe, both selects and a lane overlap.
// - Write data is stable before and after the edge ending the write.
// - Address stable well before write end, held until write end.
// - Address valid no later than the start of the write.
// - Lane enable low long enough before write end.
// - Write data stable at least its setup time before write end.
// - Strobe pulse at least turn-off time plus data setup.
// - Deselect the memory before entering retention.
// - Retention may start at once after deselection.
// - Write enable stays high throughout every read.
module asc_sram_ctrl
	import asc_pkg::*;
#(
	parameter bit SLOW_GRADE = 1'b0,
	parameter int AW         = 20,
	parameter int DW         = 16,
	parameter int TW         = 4
) (
	input  wire logic          CLK_SYS,
	input  wire logic          SRST,
	input  wire logic          CE,
	input  wire logic          REQ_VALID,
	input  wire logic          REQ_WRITE,
	input  wire logic [AW-1:0] REQ_ADDR,
	input  wire logic [DW-1:0] REQ_WDATA,
	input  wire logic [1:0]    REQ_BE,
	output logic               REQ_READY,
	output logic               RSP_VALID,
	output logic [DW-1:0]      RSP_RDATA,
	output logic               RSP_ERR,
	input  wire logic          RET_REQ,
	output logic               RET_ACTIVE,
	output logic [AW-1:0]      MEM_ADDR,
	output logic               CHIP_SELECT_LOW_ACTIVE,
	output logic               CHIP_SELECT_HIGH_ACTIVE,
	output logic               UPPER_BYTE_LANE_N,
	output logic               LOWER_BYTE_LANE_N,
	output logic               WRITE_ENABLE_N,
	output logic               OUTPUT_ENABLE_N,
	input  wire logic [DW-1:0] MEM_DQ_I,
	output logic [DW-1:0]      MEM_DQ_O,
	output logic               MEM_DQ_OE,
	input  wire logic          MEM_ERR
);

	`include "asc_map.svh"

	// ****************************************************************
	// Phase lengths in cycles
	// ****************************************************************
	localparam int C_ACC_AA  = `ASC_NS2CYC(SLOW_GRADE ?
		`ASC_T_ACCESS_SLOW_NS : `ASC_T_ACCESS_FAST_NS);
	localparam int C_ACC_OE  = `ASC_NS2CYC(SLOW_GRADE ?
		`ASC_T_OE_ACCESS_SLOW_NS : `ASC_T_OE_ACCESS_FAST_NS);
	localparam int C_ACC     = (C_ACC_AA > C_ACC_OE) ? C_ACC_AA : C_ACC_OE;
	localparam int C_RD      = C_ACC + `ASC_SYNC_STAGES;
	localparam int C_TURN    = `ASC_NS2CYC(`ASC_T_TURN_OFF_NS);
	localparam int C_WEND    = `ASC_NS2CYC(SLOW_GRADE ?
		`ASC_T_WEND_SLOW_NS : `ASC_T_WEND_FAST_NS);
	localparam int C_WSET    = `ASC_NS2CYC(`ASC_T_WDATA_SETUP_NS);
	localparam int C_WOFF    = `ASC_NS2CYC((SLOW_GRADE ?
		`ASC_T_WOFF_SLOW_NS : `ASC_T_WOFF_FAST_NS) +
		`ASC_T_WDATA_SETUP_NS);
	localparam int C_CYC     = `ASC_NS2CYC(SLOW_GRADE ?
		`ASC_T_CYCLE_SLOW_NS : `ASC_T_CYCLE_FAST_NS);
	localparam int C_W1      = (C_WEND > C_WSET) ? C_WEND : C_WSET;
	localparam int C_W2      = (C_W1 > C_WOFF) ? C_W1 : C_WOFF;
	localparam int C_PULSE   = (C_W2 > C_CYC - 2) ? C_W2 : C_CYC - 2;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (DW != 16) begin : g_bad_dw
		$error("Data width must be 16 for two byte lanes");
	end
	if (AW < 1) begin : g_bad_aw
		$error("Address width must be at least 1");
	end
	if (C_RD > (1 << TW) || C_PULSE > (1 << TW) ||
		C_CYC > (1 << TW) || C_TURN > (1 << TW)) begin : g_bad_tw
		$error("Timer width too small for phase lengths");
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	asc_state_t         state_reg;
	asc_state_t         state_next;
	logic               tmr_load;
	logic [TW-1:0]      tmr_value;
	logic               tmr_done;
	logic               accept;
	logic [DW-1:0]      dq_meta_reg;
	logic [DW-1:0]      dq_sync_reg;
	logic               err_meta_reg;
	logic               err_sync_reg;
	logic [DW-1:0]      rd_masked;
	asc_lane_t          be_reg;
	logic               ready_reg;
	logic               rsp_valid_reg;
	logic [DW-1:0]      rsp_rdata_reg;
	logic               rsp_err_reg;
	logic               ret_reg;
	logic [AW-1:0]      addr_reg;
	logic               cs_low_reg;
	logic               cs_high_reg;
	asc_lane_t          lane_n_reg;
	logic               we_n_reg;
	logic               oe_n_reg;
	logic [DW-1:0]      dq_o_reg;
	logic               dq_oe_reg;
	logic               sel_next;

	assign accept = REQ_VALID && ready_reg && !RET_REQ;

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			dq_meta_reg  <= '0;
			dq_sync_reg  <= '0;
			err_meta_reg <= 1'b0;
			err_sync_reg <= 1'b0;
		end else if (CE) begin
			dq_meta_reg  <= MEM_DQ_I;
			dq_sync_reg  <= dq_meta_reg;
			err_meta_reg <= MEM_ERR;
			err_sync_reg <= err_meta_reg;
		end
	end

	for (genvar l = 0; l < 2; l++) begin : g_lane
		assign rd_masked[l*8 +: 8] = be_reg[l] ? dq_sync_reg[l*8 +: 8]
			: 8'h00;
	end

	// ****************************************************************
	// Phase sequencer
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		tmr_load   = 1'b0;
		tmr_value  = '0;
		unique case (state_reg)
			ASC_IDLE: begin
				if (RET_REQ) begin
					state_next = ASC_RETAIN;
				end else if (accept && REQ_WRITE) begin
					state_next = ASC_WR_SETUP;
				end else if (accept) begin
					state_next = ASC_RD_ACCESS;
					tmr_load   = 1'b1;
					tmr_value  = TW'(C_RD - 1);
				end
			end
			ASC_RD_ACCESS: begin
				if (tmr_done) begin
					state_next = ASC_RD_TURN;
					tmr_load   = 1'b1;
					tmr_value  = TW'(C_TURN - 1);
				end
			end
			ASC_RD_TURN: begin
				if (tmr_done) begin
					state_next = ASC_IDLE;
				end
			end
			ASC_WR_SETUP: begin
				state_next = ASC_WR_PULSE;
				tmr_load   = 1'b1;
				tmr_value  = TW'(C_PULSE - 1);
			end
			ASC_WR_PULSE: begin
				if (tmr_done) begin
					state_next = ASC_WR_HOLD;
				end
			end
			ASC_WR_HOLD: begin
				state_next = ASC_IDLE;
			end
			ASC_RETAIN: begin
				if (!RET_REQ) begin
					state_next = ASC_RECOVER;
					tmr_load   = 1'b1;
					tmr_value  = TW'(C_CYC - 1);
				end
			end
			ASC_RECOVER: begin
				if (tmr_done) begin
					state_next = ASC_IDLE;
				end
			end
		endcase
	end

	asc_timer #(
		.TW (TW)
	) u_timer (
		.clk   (CLK_SYS),
		.srst  (SRST),
		.ce    (CE),
		.load  (tmr_load),
		.value (tmr_value),
		.done  (tmr_done)
	);

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state_reg <= ASC_RETAIN;
		end else if (CE) begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// User handshake and response
	// ****************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ready_reg     <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_rdata_reg <= '0;
			rsp_err_reg   <= 1'b0;
			ret_reg       <= 1'b0;
		end else if (CE) begin
			ready_reg     <= (state_next == ASC_IDLE) && !RET_REQ;
			rsp_valid_reg <= 1'b0;
			ret_reg       <= (state_next == ASC_RETAIN);
			if (state_reg == ASC_RD_ACCESS && tmr_done) begin
				rsp_valid_reg <= 1'b1;
				rsp_rdata_reg <= rd_masked;
				rsp_err_reg   <= err_sync_reg;
			end
		end
	end

	// ****************************************************************
	// Memory pins
	// ****************************************************************
	assign sel_next = (state_next == ASC_RD_ACCESS) ||
		(state_next == ASC_WR_SETUP) || (state_next == ASC_WR_PULSE) ||
		(state_next == ASC_WR_HOLD);

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			addr_reg    <= '0;
			be_reg      <= 2'h0;
			dq_o_reg    <= '0;
			cs_low_reg  <= 1'b1;
			cs_high_reg <= 1'b0;
			lane_n_reg  <= `ASC_LANES_OFF;
			we_n_reg    <= 1'b1;
			oe_n_reg    <= 1'b1;
			dq_oe_reg   <= 1'b0;
		end else if (CE) begin
			if (accept) begin
				addr_reg <= REQ_ADDR;
				be_reg   <= REQ_BE;
				dq_o_reg <= REQ_WDATA;
			end
			cs_low_reg  <= !sel_next;
			cs_high_reg <= sel_next;
			lane_n_reg  <= !sel_next ? `ASC_LANES_OFF
				: (accept ? ~REQ_BE : ~be_reg);
			we_n_reg    <= !(state_next == ASC_WR_PULSE);
			oe_n_reg    <= !(state_next == ASC_RD_ACCESS);
			dq_oe_reg   <= (state_next == ASC_WR_SETUP) ||
				(state_next == ASC_WR_PULSE) ||
				(state_next == ASC_WR_HOLD);
		end
	end

	assign REQ_READY               = ready_reg;
	assign RSP_VALID               = rsp_valid_reg;
	assign RSP_RDATA               = rsp_rdata_reg;
	assign RSP_ERR                 = rsp_err_reg;
	assign RET_ACTIVE              = ret_reg;
	assign MEM_ADDR                = addr_reg;
	assign CHIP_SELECT_LOW_ACTIVE  = cs_low_reg;
	assign CHIP_SELECT_HIGH_ACTIVE = cs_high_reg;
	assign UPPER_BYTE_LANE_N       = lane_n_reg[1];
	assign LOWER_BYTE_LANE_N       = lane_n_reg[0];
	assign WRITE_ENABLE_N          = we_n_reg;
	assign OUTPUT_ENABLE_N         = oe_n_reg;
	assign MEM_DQ_O                = dq_o_reg;
	assign MEM_DQ_OE               = dq_oe_reg;

endmodule

/* asc_sram_ctrl_assertions.sv */
// Purpose: Pin timing checks of the SRAM cycle controller
// Assumes: Default widths, CE held high
// Notes:   Bound into asc_sram_ctrl
module asc_chk #(
	parameter bit SLOW_GRADE = 1'b0
) (
	input wire logic        CLK_SYS,
	input wire logic        SRST,
	input wire logic        REQ_READY,
	input wire logic        RSP_VALID,
	input wire logic        RET_ACTIVE,
	input wire logic [19:0] MEM_ADDR,
	input wire logic        CHIP_SELECT_LOW_ACTIVE,
	input wire logic        CHIP_SELECT_HIGH_ACTIVE,
	input wire logic        UPPER_BYTE_LANE_N,
	input wire logic        LOWER_BYTE_LANE_N,
	input wire logic        WRITE_ENABLE_N,
	input wire logic        OUTPUT_ENABLE_N,
	input wire logic [15:0] MEM_DQ_O,
	input wire logic        MEM_DQ_OE
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RD = SLOW_GRADE ? 8 : 7;
	localparam int CY = SLOW_GRADE ? 5 : 4;
	logic       sel;
	logic       wn;
	logic       on;
	logic [1:0] ln;
	assign sel = !CHIP_SELECT_LOW_ACTIVE && CHIP_SELECT_HIGH_ACTIVE;
	assign wn = WRITE_ENABLE_N;
	assign on = OUTPUT_ENABLE_N;
	assign ln = {UPPER_BYTE_LANE_N, LOWER_BYTE_LANE_N};
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	// ********
	// Checks
	// ********
	property p_rd_we; !on |-> wn; endproperty
	a_rd_we: assert property (p_rd_we)
		else $error("strobe low during read");
	property p_pulse; $fell(wn) |-> (!wn && sel)[*5] ##1 wn; endproperty
	a_pulse: assert property (p_pulse)
		else $error("write pulse length wrong");
	property p_addr; !wn |-> sel && $stable(MEM_ADDR) && $stable(ln);
	endproperty
	a_addr: assert property (p_addr)
		else $error("address or lanes moved in write");
	property p_data; !wn |-> MEM_DQ_OE && on && $stable(MEM_DQ_O);
	endproperty
	a_data: assert property (p_data)
		else $error("write data not stable");
	property p_hold;
		$rose(wn) |-> sel && MEM_DQ_OE && $stable(MEM_ADDR) && $stable(MEM_DQ_O);
	endproperty
	a_hold: assert property (p_hold)
		else $error("no hold after write end");
	property p_ret;
		RET_ACTIVE |-> !sel && ln == 2'h3 && wn && on && !MEM_DQ_OE;
	endproperty
	a_ret: assert property (p_ret)
		else $error("memory selected in retention");
	property p_rdlat; $fell(on) |-> ##[RD:RD] RSP_VALID; endproperty
	a_rdlat: assert property (p_rdlat)
		else $error("read latency wrong");
	property p_turn; $rose(on) |-> !MEM_DQ_OE[*2]; endproperty
	a_turn: assert property (p_turn)
		else $error("bus driven too soon after read");
	property p_rec;
		$fell(RET_ACTIVE) |-> (!REQ_READY throughout (1'b1 ##CY 1'b1))
			##1 REQ_READY;
	endproperty
	a_rec: assert property (p_rec)
		else $error("recovery wait wrong");
	c_rd: cover property ($rose(RSP_VALID));
	c_wr: cover property ($rose(wn));
	c_ret: cover property ($fell(RET_ACTIVE));
endmodule

bind asc_sram_ctrl asc_chk #(.SLOW_GRADE(SLOW_GRADE)) i_asc_chk (
	.CLK_SYS(CLK_SYS),
	.SRST(SRST),
	.REQ_READY(REQ_READY),
	.RSP_VALID(RSP_VALID),
	.RET_ACTIVE(RET_ACTIVE),
	.MEM_ADDR(MEM_ADDR),
	.CHIP_SELECT_LOW_ACTIVE(CHIP_SELECT_LOW_ACTIVE),
	.CHIP_SELECT_HIGH_ACTIVE(CHIP_SELECT_HIGH_ACTIVE),
	.UPPER_BYTE_LANE_N(UPPER_BYTE_LANE_N),
	.LOWER_BYTE_LANE_N(LOWER_BYTE_LANE_N),
	.WRITE_ENABLE_N(WRITE_ENABLE_N),
	.OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
	.MEM_DQ_O(MEM_DQ_O),
	.MEM_DQ_OE(MEM_DQ_OE)
);

/* asc_sram_model.sv */
// Purpose: Behavioural asynchronous ECC SRAM
// Assumes: 1M x 16, times in ns
// Notes:   Undriven lanes toggle every ns
module asc_sram_model #(
	parameter bit SLOW = 1'b0
) (
	input  wire logic [19:0] a,
	input  wire logic        csl,
	input  wire logic        csh,
	input  wire logic        ubn,
	input  wire logic        lbn,
	input  wire logic        wen,
	input  wire logic        oen,
	input  wire logic [15:0] d,
	output logic      [15:0] q,
	output logic             err
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam real TA = SLOW ? 55.0 : 45.0;
	localparam real TO = SLOW ? 25.0 : 22.0;
	logic [15:0] mem [logic [19:0]];
	logic [15:0] v;
	realtime     t_a, t_s, t_o;
	logic        sel, wr, rd;
	assign sel = !csl && csh;
	assign wr = sel && !wen && !(ubn && lbn);
	assign rd = sel && !oen && wen && !(ubn && lbn);
	initial begin
		q = 16'h0000;
		err = 1'b0;
	end
	always @(a) t_a = $realtime;
	always @(sel, ubn, lbn) t_s = $realtime;
	always @(oen) t_o = $realtime;
	always @(negedge wr) begin
		if (^a !== 1'bx) begin
			v = mem.exists(a) ? mem[a] : 16'h0000;
			if (!ubn) v[15:8] = d[15:8];
			if (!lbn) v[7:0] = d[7:0];
			mem[a] = v;
		end
	end
	always #1 begin
		if (!rd || $realtime - t_a >= 10.0) begin
			if (rd && $realtime - t_a >= TA && $realtime - t_s >= TA
				&& $realtime - t_o >= TO) begin
				v = mem.exists(a) ? mem[a] : 16'h0000;
				q[15:8] = ubn ? ~q[15:8] : v[15:8];
				q[7:0] = lbn ? ~q[7:0] : v[7:0];
				err = a[0] ^ a[7];
			end else begin
				q = ~q;
				err = ~err;
			end
		end
	end
endmodule

/* tb.sv */
// Purpose: Self-checking bench of the SRAM cycle controller
// Assumes: Fast grade, CE held high
// Notes:   Random traffic over a small address set
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys, srst, req_valid, req_write, ret_req, req_ready;
	logic        rsp_valid, rsp_err, ret_active, csl, csh, ubn, lbn;
	logic        wen, oen, dq_oe, merr;
	logic [1:0]  req_be;
	logic [19:0] req_addr, mem_addr;
	logic [15:0] req_wdata, rsp_rdata, dq_o, mq, bus;
	logic [15:0] shadow [logic [19:0]];
	logic [31:0] seed;
	int          n_mismatch, comparisons;
	assign bus = dq_oe ? dq_o : mq;
	asc_sram_ctrl #(.SLOW_GRADE(1'b0)) i_asc_sram_ctrl (
		.CLK_SYS(clk_sys), .SRST(srst), .CE(1'b1), .REQ_VALID(req_valid),
		.REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
		.REQ_BE(req_be), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
		.RSP_RDATA(rsp_rdata), .RSP_ERR(rsp_err), .RET_REQ(ret_req),
		.RET_ACTIVE(ret_active), .MEM_ADDR(mem_addr),
		.CHIP_SELECT_LOW_ACTIVE(csl), .CHIP_SELECT_HIGH_ACTIVE(csh),
		.UPPER_BYTE_LANE_N(ubn), .LOWER_BYTE_LANE_N(lbn),
		.WRITE_ENABLE_N(wen), .OUTPUT_ENABLE_N(oen), .MEM_DQ_I(bus),
		.MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .MEM_ERR(merr));
	asc_sram_model #(.SLOW(1'b0)) i_asc_sram_model (
		.a(mem_addr), .csl(csl), .csh(csh), .ubn(ubn), .lbn(lbn),
		.wen(wen), .oen(oen), .d(bus), .q(mq), .err(merr));
	// ********
	// Helpers
	// ********
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [15:0] exp_rd(input logic [19:0] a,
		input logic [1:0] be);
		logic [15:0] v;
		v = shadow.exists(a) ? shadow[a] : 16'h0000;
		return v & {{8{be[1]}}, {8{be[0]}}};
	endfunction
	task automatic chk_d(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic access(input logic w, input logic [19:0] a,
		input logic [15:0] d, input logic [1:0] be);
		int          n;
		logic [15:0] v;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		chk_b(req_ready, 1'b1);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_be <= be;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		req_wdata <= ~d;
		if (w) begin
			v = shadow.exists(a) ? shadow[a] : 16'h0000;
			if (be[1]) v[15:8] = d[15:8];
			if (be[0]) v[7:0] = d[7:0];
			shadow[a] = v;
		end else begin
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (rsp_valid !== 1'b1 && n < 20);
			chk_d(16'(n), 16'h0008);
			chk_d(rsp_rdata, exp_rd(a, be));
			if (be != 2'h0) chk_b(rsp_err, a[0] ^ a[7]);
		end
	endtask
	task automatic give_verdict();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{srst, req_valid, req_write, ret_req} = 4'h8;
		{req_addr, req_wdata, req_be} = '0;
		n_mismatch = 0;
		comparisons = 0;
		seed = 32'd78215;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		access(1'b1, 20'hFFFFF, 16'hA55A, 2'h3);
		access(1'b1, 20'h00000, 16'h1234, 2'h3);
		access(1'b1, 20'h00000, 16'hBEEF, 2'h1);
		access(1'b1, 20'h00000, 16'h7777, 2'h0);
		access(1'b0, 20'h00000, 16'h0000, 2'h3);
		access(1'b0, 20'hFFFFF, 16'h0000, 2'h2);
		access(1'b0, 20'hFFFFF, 16'h0000, 2'h0);
		repeat (60) begin
			seed = xs(seed);
			access(seed[31], {seed[19], 15'h0000, seed[3:0]}, seed[27:12],
				seed[9:8]);
		end
		do @(posedge clk_sys); while (req_ready !== 1'b1);
		ret_req <= 1'b1;
		req_valid <= 1'b1;
		req_write <= 1'b1;
		req_addr <= 20'h00000;
		req_wdata <= 16'h0BAD;
		req_be <= 2'h3;
		repeat (2) @(posedge clk_sys);
		chk_b(ret_active, 1'b1);
		chk_b(csl, 1'b1);
		repeat (10) @(posedge clk_sys);
		chk_b(req_ready, 1'b0);
		req_valid <= 1'b0;
		ret_req <= 1'b0;
		access(1'b0, 20'h00000, 16'h0000, 2'h3);
		give_verdict();
	end
endmodule
